// File: logic/ccr_register_bank.sv
// control and status register bank of the single-cell charger
//
// Contract
// - writing one to kick bit restarts timer
// - kick bit reads the boost request pin
// - status pin low when charging, pulses faults
// - charge state field reports ready/charging/done/fault
// - boost bit shows boost mode active
// - fault bits give charge or boost fault
// - input current limit field is read-write
// - weak battery threshold field selects 3.4-3.7 V
// - termination enable bit is read-write
// - charger enable bit is active low
// - high impedance select bit is read-write
// - operating mode bit selects charge or boost
// - float voltage code defaults to 000010
// - polarity bit sets boost pin active level
// - enable bit makes boost pin honoured
// - identification register is read-only fixed fields
// - soft reset bit restores charge parameters
// - max charge current field is read-write
// - charge current bit 3 reads one
// - termination current field is read-write
// - bytes travel most significant bit first
`timescale 1ns/1ps
module ccr_register_bank #(
  parameter logic [2:0] SUPPLIER_CODE = 3'h3, // arbitrary value
  parameter logic [2:0] PART_NUMBER = 3'h2, // arbitrary value
  parameter logic [1:0] REVISION = 2'h1 // arbitrary value
) (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] reg_addr, // register address from serial engine
  input wire logic [7:0] reg_wdata, // write byte, bit 7 first on the wire
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read byte, bit 7 first on the wire
  output logic reg_rvalid, // read byte valid, one cycle
  input wire logic boost_request_pin, // external boost request pin, async
  input wire ccr_pkg::ccr_status_s status, // live charger status
  input wire logic fault_blink, // fault pulse pattern from charger
  output logic safety_timer_kick, // one-cycle timer restart pulse
  output logic stat_out, // status pin level, always low
  output logic stat_oe_n, // status pin enable, low drives low
  output logic boost_request, // qualified boost request level
  output ccr_pkg::ccr_cfg_s cfg // configuration to the charger
);
  import ccr_pkg::*;

  // register state
  logic en_stat_r;
  logic [7:0] mode_cfg_r;
  logic [7:0] float_cfg_r;
  logic [2:0] max_charge_r;
  logic [2:0] term_current_r;
  logic kick_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic stat_oe_n_r;
  logic boost_req_r;
  logic [CCR_SYNC_STAGES-1:0] pin_sync_r;
  logic pin_lvl_r;

  // address decode
  wire wr_ctrl = reg_wr && (reg_addr == CCR_ADDR_CONTROL_STATUS);
  wire wr_mode = reg_wr && (reg_addr == CCR_ADDR_MODE_CONFIG);
  wire wr_float = reg_wr && (reg_addr == CCR_ADDR_FLOAT_VOLTAGE);
  wire wr_charge_current_config = reg_wr && (reg_addr == CCR_ADDR_CHARGE_CURRENT);
  wire soft_reset = wr_charge_current_config && reg_wdata[CCR_BIT_SOFT_RESET];
  wire is_id = (reg_addr == CCR_ADDR_CHIP_ID) || (reg_addr == CCR_ADDR_CHIP_ID_ALT);

  // register images as read back
  wire [7:0] ctrl_img = {pin_lvl_r, en_stat_r, status.charge_state, status.boost_active,
                         status.fault_code};
  wire [7:0] id_img = {SUPPLIER_CODE, PART_NUMBER, REVISION};
  wire [7:0] charge_current_config_img = {1'b1, max_charge_r, 1'b1, term_current_r};

  // read multiplexer, unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_addr == CCR_ADDR_CONTROL_STATUS) ? ctrl_img :
    (reg_addr == CCR_ADDR_MODE_CONFIG) ? mode_cfg_r :
    (reg_addr == CCR_ADDR_FLOAT_VOLTAGE) ? float_cfg_r :
    is_id ? id_img :
    (reg_addr == CCR_ADDR_CHARGE_CURRENT) ? charge_current_config_img : CCR_RDATA_UNMAPPED;

  // next values of the charge parameters
  wire [7:0] mode_nxt = soft_reset ? CCR_RST_MODE_CONFIG :
                        wr_mode ? reg_wdata : mode_cfg_r;
  wire [7:0] float_nxt = soft_reset ? CCR_RST_FLOAT_VOLTAGE :
                         wr_float ? reg_wdata : float_cfg_r;
  wire [2:0] max_charge_nxt = soft_reset ? CCR_RST_CHARGE_CURRENT[6:4] :
                              wr_charge_current_config ? reg_wdata[6:4] : max_charge_r;
  wire [2:0] term_nxt = soft_reset ? CCR_RST_CHARGE_CURRENT[2:0] :
                        wr_charge_current_config ? reg_wdata[2:0] : term_current_r;
  // only the enable bit of control_status is stored; a one in the kick bit gives a pulse
  wire en_stat_nxt = wr_ctrl ? reg_wdata[CCR_BIT_EN_STAT] : en_stat_r;
  wire kick_nxt = wr_ctrl && reg_wdata[CCR_BIT_KICK];

  // status pin: low while charging if enabled, and on fault pulses
  wire stat_low = (en_stat_r && (status.charge_state == CCR_STATE_CHARGING))
                  || fault_blink;

  // boost request from pin after polarity and enable
  wire pin_active = cfg.boost_request_polarity ? pin_lvl_r : !pin_lvl_r;
  wire boost_req_nxt = cfg.boost_request_enable && pin_active;

  // boost request pin synchroniser, change taken when last two agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_r <= '0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[CCR_SYNC_STAGES-2:0], boost_request_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_lvl_r <= pin_sync_r[2];
      end
    end
  end

  // writable registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      en_stat_r <= CCR_RST_EN_STAT;
      mode_cfg_r <= CCR_RST_MODE_CONFIG;
      float_cfg_r <= CCR_RST_FLOAT_VOLTAGE;
      max_charge_r <= CCR_RST_CHARGE_CURRENT[6:4];
      term_current_r <= CCR_RST_CHARGE_CURRENT[2:0];
    end else begin
      en_stat_r <= en_stat_nxt;
      mode_cfg_r <= mode_nxt;
      float_cfg_r <= float_nxt;
      max_charge_r <= max_charge_nxt;
      term_current_r <= term_nxt;
    end
  end

  // read answer, pulses and pins, all registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= CCR_RDATA_UNMAPPED;
      rvalid_r <= 1'b0;
      kick_r <= 1'b0;
      stat_oe_n_r <= 1'b1;
      boost_req_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : rdata_r; // bit 7 leads on the wire
      rvalid_r <= reg_rd;
      kick_r <= kick_nxt;
      stat_oe_n_r <= !stat_low;
      boost_req_r <= boost_req_nxt;
    end
  end

  // outputs straight from flops, except stat_out tied low
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign safety_timer_kick = kick_r;
  assign stat_out = 1'b0; // open drain, only pulls low
  assign stat_oe_n = stat_oe_n_r;
  assign boost_request = boost_req_r;

  // configuration fields from stored registers
  assign cfg.input_current_limit = mode_cfg_r[7:6];
  assign cfg.weak_battery_threshold = mode_cfg_r[5:4];
  assign cfg.termination_enable = mode_cfg_r[3];
  assign cfg.charger_disable = mode_cfg_r[2];
  assign cfg.high_impedance_select = mode_cfg_r[1];
  assign cfg.operating_mode_select = mode_cfg_r[0];
  assign cfg.float_voltage_code = float_cfg_r[7:2];
  assign cfg.boost_request_polarity = float_cfg_r[1];
  assign cfg.boost_request_enable = float_cfg_r[0];
  assign cfg.max_charge_current = max_charge_r;
  assign cfg.termination_current = term_current_r;

  // checks on the register bank behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_kick_write;
    reg_wr && (reg_addr == CCR_ADDR_CONTROL_STATUS) && reg_wdata[7];
  endsequence

  sequence s_one_pulse;
    safety_timer_kick ##1 (!safety_timer_kick || $past(kick_nxt));
  endsequence

  a_kick_one_pulse: assert property (s_kick_write |=> s_one_pulse)
    else $error("timer kick not a single pulse after write");

  a_kick_needs_write: assert property (safety_timer_kick |-> $past(wr_ctrl) && $past(reg_wdata[7]))
    else $error("timer kick without a write of one");

  a_read_pin_level: assert property (reg_rd && (reg_addr == CCR_ADDR_CONTROL_STATUS)
    |=> reg_rvalid && (reg_rdata[7] == $past(pin_lvl_r)))
    else $error("kick bit does not read pin level");

  a_stat_charging: assert property (en_stat_r && !en_stat_nxt == 1'b0 && !fault_blink
    && status.charge_state == CCR_STATE_CHARGING |=> !stat_oe_n)
    else $error("status pin not low while charging");

  a_stat_disabled: assert property (!en_stat_r && !fault_blink |=> stat_oe_n)
    else $error("status pin low with charging indication off");

  a_stat_fault: assert property (fault_blink |=> !stat_oe_n)
    else $error("status pin misses fault pulse");

  a_status_readback: assert property (reg_rd && (reg_addr == CCR_ADDR_CONTROL_STATUS)
    |=> reg_rdata[5:0] == $past({status.charge_state, status.boost_active,
    status.fault_code}))
    else $error("status fields read back wrong");

  a_mode_write: assert property (wr_mode && !soft_reset
    |=> cfg.input_current_limit == $past(reg_wdata[7:6])
    && cfg.operating_mode_select == $past(reg_wdata[0]))
    else $error("mode register write not applied");

  a_id_fixed: assert property (reg_rd && is_id |=> reg_rdata == id_img)
    else $error("identification read wrong");

  a_soft_reset: assert property (soft_reset |=> mode_cfg_r == CCR_RST_MODE_CONFIG
    && float_cfg_r == CCR_RST_FLOAT_VOLTAGE && charge_current_config_img == CCR_RST_CHARGE_CURRENT)
    else $error("soft reset left a parameter changed");

  a_charge_current_config_fixed_ones: assert property (reg_rd && (reg_addr == CCR_ADDR_CHARGE_CURRENT)
    |=> reg_rdata[7] && reg_rdata[3])
    else $error("charge current fixed bits not one");

  a_ro_write_ignored: assert property (wr_ctrl |=> en_stat_r == $past(reg_wdata[6])
    ##0 $stable(mode_cfg_r))
    else $error("control write disturbed other state");

  a_boost_request: assert property (##1 boost_request == $past(boost_req_nxt)
    && (!$past(cfg.boost_request_enable) -> !boost_request))
    else $error("boost request ignores enable or polarity");

  // a zero in the kick bit never restarts the timer
  a_kick_zero_write: assert property (wr_ctrl && !reg_wdata[CCR_BIT_KICK]
    |=> !safety_timer_kick)
    else $error("timer kick after a write of zero");

  // mode register reads back what is stored
  a_mode_readback: assert property (reg_rd && (reg_addr == CCR_ADDR_MODE_CONFIG)
    |=> reg_rdata == $past(mode_cfg_r))
    else $error("mode register read back wrong");

  // weak battery threshold follows the written code
  a_threshold_field: assert property (wr_mode && !soft_reset
    |=> cfg.weak_battery_threshold == $past(reg_wdata[5:4]))
    else $error("weak battery threshold not applied");

  // termination enable follows the written bit
  a_term_enable: assert property (wr_mode && !soft_reset
    |=> cfg.termination_enable == $past(reg_wdata[3]))
    else $error("termination enable not applied");

  // charger disable bit is stored as written, one disables
  a_charger_disable: assert property (wr_mode && !soft_reset
    |=> cfg.charger_disable == $past(reg_wdata[2]))
    else $error("charger enable bit not applied");

  // high impedance select follows the written bit
  a_hiz_select: assert property (wr_mode && !soft_reset
    |=> cfg.high_impedance_select == $past(reg_wdata[1]))
    else $error("high impedance select not applied");

  // mode register keeps its value without a write
  a_mode_hold: assert property (!wr_mode && !soft_reset
    |=> $stable(mode_cfg_r))
    else $error("mode register changed without a write");

  // float voltage code follows the written field
  a_float_write: assert property (wr_float && !soft_reset
    |=> cfg.float_voltage_code == $past(reg_wdata[7:2]))
    else $error("float voltage code not applied");

  // float register reads back what is stored
  a_float_readback: assert property (reg_rd && (reg_addr == CCR_ADDR_FLOAT_VOLTAGE)
    |=> reg_rdata == $past(float_cfg_r))
    else $error("float register read back wrong");

  // soft reset restores the float voltage code
  a_float_default: assert property (soft_reset
    |=> cfg.float_voltage_code == CCR_RST_FLOAT_VOLTAGE[7:2])
    else $error("float voltage code not restored");

  // boost pin polarity bit follows the write
  a_polarity_write: assert property (wr_float && !soft_reset
    |=> cfg.boost_request_polarity == $past(reg_wdata[1]))
    else $error("boost pin polarity not applied");

  // active high pin passes straight through when enabled
  a_boost_polarity: assert property (cfg.boost_request_enable && cfg.boost_request_polarity
    |=> boost_request == $past(pin_lvl_r))
    else $error("active high boost pin not honoured");

  // boost pin enable bit follows the write
  a_enable_write: assert property (wr_float && !soft_reset
    |=> cfg.boost_request_enable == $past(reg_wdata[0]))
    else $error("boost pin enable not applied");

  // disabled pin never raises a boost request
  a_boost_disabled: assert property (!cfg.boost_request_enable
    |=> !boost_request)
    else $error("boost request while pin disabled");

  // identification reads the fixed code fields
  a_id_value: assert property (reg_rd && is_id
    |=> reg_rdata == {SUPPLIER_CODE, PART_NUMBER, REVISION})
    else $error("identification fields wrong");

  // soft reset leaves the status pin enable alone
  a_soft_keeps_stat: assert property (soft_reset
    |=> $stable(en_stat_r))
    else $error("soft reset touched status pin enable");

  // max charge current follows the written field
  a_current_write: assert property (wr_charge_current_config && !soft_reset
    |=> cfg.max_charge_current == $past(reg_wdata[6:4]))
    else $error("max charge current not applied");

  // fixed ones survive any charge current write
  a_charge_current_config_ones_kept: assert property (wr_charge_current_config && !soft_reset
    |=> charge_current_config_img[7] && charge_current_config_img[3])
    else $error("charge current fixed bits lost");

  // termination current follows the written field
  a_term_current: assert property (wr_charge_current_config && !soft_reset
    |=> cfg.termination_current == $past(reg_wdata[2:0]))
    else $error("termination current not applied");

  // every read strobe gets exactly one valid cycle
  a_read_valid: assert property (reg_rd
    |=> reg_rvalid)
    else $error("read strobe without valid");

  // valid never shows without a read strobe
  a_no_stray_valid: assert property (!reg_rd
    |=> !reg_rvalid)
    else $error("valid without a read strobe");

  // read byte holds until the next read
  a_rdata_holds: assert property (!reg_rd
    |=> $stable(reg_rdata))
    else $error("read byte changed without a read");

  // unmapped addresses read as zero
  a_unmapped_read: assert property (reg_rd && (reg_addr > CCR_ADDR_CHARGE_CURRENT) && !is_id
    |=> reg_rdata == CCR_RDATA_UNMAPPED)
    else $error("unmapped address read not zero");

  // status pin enable changes only on a control write
  a_stat_en_hold: assert property (!wr_ctrl
    |=> $stable(en_stat_r))
    else $error("status pin enable changed without a write");

  // pin level moves only once the last two stages agree
  a_sync_agree: assert property ($changed(pin_lvl_r)
    |-> $past(pin_sync_r[1] == pin_sync_r[2]))
    else $error("pin level taken before stages agree");

  // status pin released when not charging and no fault
  a_stat_idle_high: assert property (!fault_blink && (status.charge_state != CCR_STATE_CHARGING)
    |=> stat_oe_n)
    else $error("status pin low without cause");

endmodule : ccr_register_bank

// File: logic/ccr_pkg.sv
// register map, reset values and carriers for the charger register bank
package ccr_pkg;

  // register addresses
  localparam logic [7:0] CCR_ADDR_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] CCR_ADDR_MODE_CONFIG = 8'h01;
  localparam logic [7:0] CCR_ADDR_FLOAT_VOLTAGE = 8'h02;
  localparam logic [7:0] CCR_ADDR_CHIP_ID = 8'h03;
  localparam logic [7:0] CCR_ADDR_CHIP_ID_ALT = 8'h3b;
  localparam logic [7:0] CCR_ADDR_CHARGE_CURRENT = 8'h04;

  // field positions
  localparam int CCR_BIT_KICK = 7;
  localparam int CCR_BIT_EN_STAT = 6;
  localparam int CCR_BIT_SOFT_RESET = 7;

  // values after reset
  localparam logic CCR_RST_EN_STAT = 1'h1;
  localparam logic [7:0] CCR_RST_MODE_CONFIG = 8'h30;
  localparam logic [7:0] CCR_RST_FLOAT_VOLTAGE = 8'h0a;
  localparam logic [7:0] CCR_RST_CHARGE_CURRENT = 8'h89;
  localparam logic [7:0] CCR_RDATA_UNMAPPED = 8'h00;

  // charge state codes
  localparam logic [1:0] CCR_STATE_READY = 2'h0;
  localparam logic [1:0] CCR_STATE_CHARGING = 2'h1;
  localparam logic [1:0] CCR_STATE_DONE = 2'h2;
  localparam logic [1:0] CCR_STATE_FAULT = 2'h3;

  // pin synchroniser depth and read latency in cycles
  localparam int CCR_SYNC_STAGES = 3;
  localparam int CCR_READ_LATENCY = 1;

  // configuration seen by the analog charger
  typedef struct packed {
    logic [1:0] input_current_limit;
    logic [1:0] weak_battery_threshold;
    logic termination_enable;
    logic charger_disable;
    logic high_impedance_select;
    logic operating_mode_select;
    logic [5:0] float_voltage_code;
    logic boost_request_polarity;
    logic boost_request_enable;
    logic [2:0] max_charge_current;
    logic [2:0] termination_current;
  } ccr_cfg_s;

  // live status reported by the analog charger
  typedef struct packed {
    logic [1:0] charge_state;
    logic boost_active;
    logic [2:0] fault_code;
  } ccr_status_s;

endpackage : ccr_pkg

// File: verif/ccr_host_model.sv
// register bus host model driving the bank's byte port
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic ref_clk, // system clock
  output logic [7:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // write byte
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read byte
  input wire logic reg_rvalid // read byte valid
);
  // bus idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write; released data shows its inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one read; byte taken at the edge that sees valid high
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    // a missing answer hands back unknowns so the compare fails
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : ccr_host_model

// File: verif/tb_charger_control_register_bank.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ps
module tb_charger_control_register_bank;
  import ccr_pkg::*;
  localparam logic [7:0] ID = {3'h6, 3'h1, 2'h2}; // arbitrary id values
  logic ref_clk, rstn, boost_request_pin, fault_blink, reg_wr, reg_rd, reg_rvalid;
  logic safety_timer_kick, stat_out, stat_oe_n, boost_request;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] st;
  ccr_status_s status;
  ccr_cfg_s cfg;
  int bad_count = 0, tests_run = 0, cyc = 0, seed = 32'h770d671a;
  int m_mode = 'h30, m_flt = 'h0a, m_cur = 'h89;
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  ccr_register_bank #(.SUPPLIER_CODE(3'h6), .PART_NUMBER(3'h1), .REVISION(2'h2)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .boost_request_pin(boost_request_pin), .status(status), .fault_blink(fault_blink),
    .safety_timer_kick(safety_timer_kick), .stat_out(stat_out), .stat_oe_n(stat_oe_n),
    .boost_request(boost_request), .cfg(cfg));
  ccr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_u.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rdchk
  // configuration registers and the fields they drive
  task automatic regs_chk();
    rdchk(8'h01, 8'(m_mode));
    rdchk(8'h02, 8'(m_flt));
    rdchk(8'h04, 8'(m_cur));
    chk("cfg mode", 8'(m_mode), cfg[21:14]);
    chk("cfg float", 8'(m_flt), cfg[13:6]);
    chk("cfg current", 8'(m_cur), {1'b1, cfg[5:3], 1'b1, cfg[2:0]});
  endtask : regs_chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    rstn = 1'b0;
    boost_request_pin = 1'b0;
    fault_blink = 1'b0;
    status = '0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    regs_chk();
    host_u.wr(8'h03, 8'h00);
    rdchk(8'h03, ID);
    rdchk(8'h3b, ID);
    rdchk(8'h05, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      if (i % 3 == 2) d[7] = 1'b0;
      host_u.wr(8'(1 + i % 3 + i % 3 / 2), d); // addresses 1, 2, 4
      if (i % 3 == 0) m_mode = d;
      else if (i % 3 == 1) m_flt = d;
      else m_cur = {1'b1, d[6:4], 1'b1, d[2:0]};
      regs_chk();
    end
    host_u.wr(8'h04, 8'($random(seed)) | 8'h80);
    m_mode = 'h30;
    m_flt = 'h0a;
    m_cur = 'h89;
    regs_chk();
    $display("test configuration done");
    host_u.wr(8'h00, 8'h80);
    @(posedge ref_clk);
    chk("kick", 8'h01, {7'h0, safety_timer_kick});
    @(posedge ref_clk);
    chk("kick end", 8'h00, {7'h0, safety_timer_kick});
    host_u.wr(8'h00, 8'h3f);
    repeat (2) @(posedge ref_clk);
    chk("no kick", 8'h00, {7'h0, safety_timer_kick});
    for (int j = 0; j < 16; j++) begin
      st = 6'($random(seed));
      st[5:4] = 2'(j >> 1);
      status <= ccr_status_s'(st);
      fault_blink <= 1'(j);
      boost_request_pin <= 1'($random(seed));
      host_u.wr(8'h00, {1'b0, 1'(j >> 3), 6'h3f});
      repeat (6) @(posedge ref_clk);
      chk("stat", {7'h0, !(j[3] && st[5:4] == 2'h1 || j[0])}, {7'h0, stat_oe_n});
      chk("stat level", 8'h00, {7'h0, stat_out});
      rdchk(8'h00, {boost_request_pin, 1'(j >> 3), st});
    end
    $display("test status done");
    for (int k = 0; k < 8; k++) begin
      host_u.wr(8'h02, {6'h02, 2'(k)});
      boost_request_pin <= k[2];
      repeat (6) @(posedge ref_clk);
      chk("boost", {7'h0, k[0] && (k[1] ? k[2] : !k[2])}, {7'h0, boost_request});
    end
    $display("test boost request done");
    stop_test();
  end
endmodule : tb_charger_control_register_bank
